// ===== dv/tfu_mem_model.sv
// memory partner that answers the load-store port after a chosen latency
`timescale 1ns/1ps
module tfu_mem_model
    import tfu_pkg::*;
#(
    parameter int unsigned ADDR_W = 32
) (
    input  wire logic              sys_clk_in,
    input  wire logic              mem_req_in,
    input  wire logic              mem_we_in,
    input  wire logic [ADDR_W-3:0] mem_addr_in,
    input  wire logic [BE_W-1:0]   mem_be_in,
    input  wire logic [LS_DW-1:0]  mem_wdata_in,
    input  wire logic [3:0]        delay_in,
    output logic      [LS_DW-1:0]  mem_rdata_out,
    output logic                   mem_rvalid_out
);
    logic [LS_DW-1:0] mem_reg [0:15];
    logic [3:0]       cnt_reg;
    logic [3:0]       word_reg;

    initial begin
        for (int i = 0; i < 16; i++) begin
            mem_reg[i] = 32'h8a4c_0000 + i;
        end
        cnt_reg = 4'h0;
        word_reg = 4'h0;
        mem_rvalid_out = 1'b0;
        mem_rdata_out = 32'h0;
    end

    // a delay of one answers in the cycle after the request, more comes late on purpose
    always @(posedge sys_clk_in) begin
        if (mem_req_in && !mem_we_in && delay_in <= 4'h1) begin
            mem_rvalid_out <= 1'b1;
            mem_rdata_out  <= mem_reg[mem_addr_in[3:0]];
        end else if (cnt_reg == 4'h1) begin
            mem_rvalid_out <= 1'b1;
            mem_rdata_out  <= mem_reg[word_reg];
        end else begin
            mem_rvalid_out <= 1'b0;
            // idle data toggles so a stale capture never passes
            mem_rdata_out  <= ~mem_rdata_out;
        end
        if (mem_req_in && !mem_we_in) begin
            cnt_reg  <= (delay_in > 4'h1) ? delay_in - 4'h1 : 4'h0;
            word_reg <= mem_addr_in[3:0];
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
        if (mem_req_in && mem_we_in) begin
            for (int b = 0; b < 4; b++) begin
                if (mem_be_in[b]) begin
                    mem_reg[mem_addr_in[3:0]][8*b+:8] <= mem_wdata_in[8*b+:8];
                end
            end
        end
    end
endmodule : tfu_mem_model

// ===== dv/tfu_shell_bench.sv
// self-checking bench for the function unit shell with a memory partner
`timescale 1ns/1ps
module tfu_shell_bench
    import tfu_pkg::*;
;
    logic        sys_clk, resetn, gstall, ats, abs_s, lts, lws;
    logic        stall_req, mreq, mwe, rvalid;
    logic [2:0]  aop, lop;
    logic [31:0] at, ab, lt, lw, ares, lres, mwd, rdata, be_res, be_wd;
    logic [29:0] maddr;
    logic [3:0]  mbe, dly, be_be;
    int          error_cnt, compares;

    tfu_shell i_tfu_shell (.sys_clk_in(sys_clk), .resetn_in(resetn), .global_stall_in(gstall),
        .stall_req_out(stall_req), .alu_trigger_operand_in(at), .alu_trigger_strobe_in(ats),
        .alu_second_operand_in(ab), .alu_operand_strobe_in(abs_s), .alu_op_select_in(aop),
        .alu_result_out(ares), .ldst_trigger_operand_in(lt), .ldst_trigger_strobe_in(lts),
        .ldst_second_operand_in(lw), .ldst_operand_strobe_in(lws), .ldst_op_select_in(lop),
        .ldst_result_out(lres), .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(maddr),
        .mem_be_out(mbe), .mem_wdata_out(mwd), .mem_rdata_in(rdata), .mem_rvalid_in(rvalid));

    // big-endian twin sees the same requests and answers
    tfu_shell #(.BIG_ENDIAN(1'b1)) i_tfu_shell_be (.sys_clk_in(sys_clk), .resetn_in(resetn),
        .global_stall_in(gstall), .stall_req_out(), .alu_trigger_operand_in(at),
        .alu_trigger_strobe_in(ats), .alu_second_operand_in(ab), .alu_operand_strobe_in(abs_s),
        .alu_op_select_in(aop), .alu_result_out(), .ldst_trigger_operand_in(lt),
        .ldst_trigger_strobe_in(lts), .ldst_second_operand_in(lw), .ldst_operand_strobe_in(lws),
        .ldst_op_select_in(lop), .ldst_result_out(be_res), .mem_req_out(), .mem_we_out(),
        .mem_addr_out(), .mem_be_out(be_be), .mem_wdata_out(be_wd), .mem_rdata_in(rdata),
        .mem_rvalid_in(rvalid));

    tfu_mem_model i_tfu_mem_model (.sys_clk_in(sys_clk), .mem_req_in(mreq), .mem_we_in(mwe),
        .mem_addr_in(maddr), .mem_be_in(mbe), .mem_wdata_in(mwd), .delay_in(dly),
        .mem_rdata_out(rdata), .mem_rvalid_out(rvalid));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic give_verdict();
        if (error_cnt == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic alu_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
                          input logic bs, input logic st, input logic [31:0] exp);
        @(posedge sys_clk);
        gstall <= st;
        aop <= op;
        at <= a;
        ab <= b;
        ats <= 1'b1;
        abs_s <= bs;
        @(posedge sys_clk);
        ats <= 1'b0;
        abs_s <= 1'b0;
        gstall <= 1'b0;
        #1;
        chk_word(ares, exp, "alu result");
    endtask : alu_op

    task automatic ls_op(input logic [2:0] op, input logic [31:0] addr, input logic [31:0] wd,
                         input logic [3:0] d, input logic [3:0] be, input logic [31:0] exp);
        int n;
        @(posedge sys_clk);
        lop <= op;
        lt <= addr;
        lw <= wd;
        lts <= 1'b1;
        lws <= 1'b1;
        dly <= d;
        @(posedge sys_clk);
        lts <= 1'b0;
        lws <= 1'b0;
        #1;
        chk_bit(mreq, 1'b1, "mem request");
        chk_bit(mwe, op > 3'h4, "mem write");
        chk_word({2'b00, maddr}, {2'b00, addr[31:2]}, "word address");
        chk_word({28'h0, mbe}, {28'h0, be}, "byte enables");
        if (op > 3'h4) begin
            chk_word(mwd, exp, "store data");
            return;
        end
        repeat (2) @(posedge sys_clk);
        #1;
        chk_bit(stall_req, d > 4'h1, "stall request");
        n = 0;
        while (stall_req !== 1'b0) begin
            if (n == 20) begin
                error_cnt++;
                $display("[FAIL] %0t load never completed", $time);
                give_verdict();
            end
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk_word(lres, exp, "load result");
    endtask : ls_op

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic sc_alu_ops();
        logic [31:0] a, b, e;
        a = 32'h8000_00f5;
        b = 32'h0000_000c;
        for (int op = 0; op < 5; op++) begin
            case (op)
                0: e = a + b;
                1: e = a & b;
                2: e = ~a;
                3: e = a - b;
                default: e = a ^ b;
            endcase
            alu_op(op[2:0], a, b, 1'b1, 1'b0, e);
        end
    endtask : sc_alu_ops

    // stored operand reuse, unused codes and stalled strobes
    task automatic sc_alu_hold();
        alu_op(ALU_ADD, 32'h1, 32'h55, 1'b0, 1'b0, 32'hd);
        alu_op(3'h5, 32'h7, 32'h7, 1'b1, 1'b0, 32'hd);
        alu_op(ALU_SUB, 32'h9, 32'h100, 1'b1, 1'b1, 32'hd);
        alu_op(ALU_ADD, 32'h1, 32'h0, 1'b0, 1'b0, 32'h0000_0008);
    endtask : sc_alu_hold

    task automatic sc_memory();
        ls_op(3'h1, 32'h10, 32'h0, 4'h1, 4'hf, 32'h8a4c_0004);
        ls_op(3'h3, 32'h12, 32'h0, 4'h1, 4'hc, 32'h0000_8a4c);
        ls_op(3'h0, 32'h12, 32'h0, 4'h2, 4'hc, 32'hffff_8a4c);
        ls_op(3'h4, 32'h10, 32'h0, 4'h1, 4'h1, 32'h0000_0004);
        ls_op(3'h2, 32'h13, 32'h0, 4'h6, 4'h8, 32'hffff_ff8a);
        ls_op(3'h7, 32'h13, 32'hab, 4'h1, 4'h8, 32'habab_abab);
        ls_op(3'h5, 32'h16, 32'h1234, 4'h1, 4'hc, 32'h1234_1234);
        ls_op(3'h6, 32'h18, 32'hdead_beef, 4'h1, 4'hf, 32'hdead_beef);
        ls_op(3'h2, 32'h13, 32'h0, 4'h1, 4'h8, 32'hffff_ffab);
        ls_op(3'h3, 32'h16, 32'h0, 4'h3, 4'hc, 32'h0000_1234);
        ls_op(3'h1, 32'h18, 32'h0, 4'h1, 4'hf, 32'hdead_beef);
    endtask : sc_memory

    // a load whose data lands while the global stall freezes the latency count
    task automatic sc_ls_stall();
        @(posedge sys_clk);
        lop <= 3'h1;
        lt <= 32'h1c;
        lts <= 1'b1;
        dly <= 4'h1;
        @(posedge sys_clk);
        lts <= 1'b0;
        gstall <= 1'b1;
        repeat (2) @(posedge sys_clk);
        gstall <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk_word(lres, 32'hdead_beef, "load result early under stall");
        @(posedge sys_clk);
        #1;
        chk_bit(stall_req, 1'b0, "stall request after frozen wait");
        chk_word(lres, 32'h8a4c_0007, "load result after stall");
    endtask : sc_ls_stall

    // same requests through the big-endian twin: other operations, other lanes
    task automatic sc_big_endian();
        ls_op(3'h4, 32'h10, 32'h0, 4'h1, 4'h1, 32'h0000_0004);
        chk_word(be_res, 32'hab4c_0004, "big endian word load");
        chk_word({28'h0, be_be}, 32'hf, "big endian word enables");
        ls_op(3'h2, 32'h10, 32'h0, 4'h1, 4'h1, 32'h0000_0004);
        chk_word(be_res, 32'hffff_ffab, "big endian signed byte");
        chk_word({28'h0, be_be}, 32'h8, "big endian byte lane");
        ls_op(3'h1, 32'h16, 32'h0, 4'h1, 4'hf, 32'h1234_0005);
        chk_word(be_res, 32'h0000_0005, "big endian unsigned half");
        chk_word({28'h0, be_be}, 32'h3, "big endian half lanes");
        ls_op(3'h6, 32'h19, 32'h0000_00cd, 4'h1, 4'hf, 32'h0000_00cd);
        chk_word({28'h0, be_be}, 32'h4, "big endian byte store lane");
        chk_word(be_wd, 32'hcdcd_cdcd, "big endian byte store data");
    endtask : sc_big_endian

    task automatic sc_reset_check();
        chk_word(ares, 32'h0, "alu result after reset");
        chk_word(lres, 32'h0, "load result after reset");
        chk_bit(mreq, 1'b0, "mem request after reset");
        chk_bit(stall_req, 1'b0, "stall request after reset");
    endtask : sc_reset_check

    task automatic sc_mid_reset();
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        sc_reset_check();
        // the operand register must have been cleared as well
        alu_op(ALU_ADD, 32'h3, 32'h0, 1'b0, 1'b0, 32'h3);
    endtask : sc_mid_reset

    initial begin
        error_cnt = 0;
        compares = 0;
        resetn = 1'b0;
        gstall = 1'b0;
        {ats, abs_s, lts, lws} = 4'h0;
        {aop, lop} = 6'h0;
        {at, ab, lt, lw} = 128'h0;
        dly = 4'h1;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        sc_reset_check();
        sc_alu_ops();
        sc_alu_hold();
        sc_memory();
        sc_ls_stall();
        sc_big_endian();
        sc_mid_reset();
        give_verdict();
    end
endmodule : tfu_shell_bench

// ===== hdl/tfu_alu.sv
// two-operand arithmetic function unit with one-cycle latency
`timescale 1ns/1ps
module tfu_alu
    import tfu_pkg::*;
#(
    parameter int unsigned DATA_W = 32
) (
    input  wire logic              sys_clk_in,
    input  wire logic              resetn_in,
    input  wire logic              global_stall_in,
    input  wire logic [DATA_W-1:0] trigger_operand_in,
    input  wire logic              trigger_strobe_in,
    input  wire logic [DATA_W-1:0] second_operand_in,
    input  wire logic              operand_strobe_in,
    input  wire logic [OP_W-1:0]   op_select_in,
    output logic      [DATA_W-1:0] result_out
);

    logic [DATA_W-1:0] operand_reg;
    logic [DATA_W-1:0] b_val;
    logic [DATA_W-1:0] result_next;
    logic              fire;

    assign fire  = trigger_strobe_in && !global_stall_in;
    // an operand moved in the same cycle as the trigger takes part at once
    assign b_val = operand_strobe_in ? second_operand_in : operand_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            operand_reg <= DATA_W'(RST_DATA);
        end else if (operand_strobe_in && !global_stall_in) begin
            operand_reg <= second_operand_in;
        end
    end

    always_comb begin
        result_next = result_out;
        unique case (op_select_in)
            ALU_ADD: result_next = trigger_operand_in + b_val;
            ALU_AND: result_next = trigger_operand_in & b_val;
            ALU_NOT: result_next = ~trigger_operand_in;
            ALU_SUB: result_next = trigger_operand_in - b_val;
            ALU_XOR: result_next = trigger_operand_in ^ b_val;
            default: result_next = result_out;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            result_out <= DATA_W'(RST_DATA);
        end else if (fire) begin
            result_out <= result_next;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    a_alu_sub_result: assert property (fire && op_select_in == ALU_SUB |=>
        result_out == $past(trigger_operand_in) - $past(b_val)) else $error("alu sub result wrong");
    a_alu_stall_hold: assert property (global_stall_in |=> $stable(result_out))
        else $error("alu result moved under stall");
    a_alu_opcode_add: assert property (fire && op_select_in == ALU_ADD |=>
        result_out == $past(trigger_operand_in) + $past(b_val)) else $error("alu add code wrong");

endmodule : tfu_alu

// ===== hdl/tfu_pkg.sv
// shared constants, opcodes and helpers for the function unit shell
package tfu_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int unsigned OP_W     = 3;
    localparam int unsigned LS_DW    = 32;
    localparam int unsigned CNT_W    = 3;
    localparam int unsigned LANE_W   = 2;
    localparam int unsigned BE_W     = 4;

    // ---------------------------------------------------------------
    // reset values and static latency
    // ---------------------------------------------------------------
    localparam logic [LS_DW-1:0] RST_DATA = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;
    localparam logic [CNT_W-1:0] LS_LAT   = 3'h3;
    localparam logic [CNT_W-1:0] LS_LAST  = LS_LAT - CNT_ONE;

    // ---------------------------------------------------------------
    // arithmetic unit opcodes, alphabetical by operation name
    // ---------------------------------------------------------------
    localparam logic [OP_W-1:0] ALU_ADD = 3'h0;
    localparam logic [OP_W-1:0] ALU_AND = 3'h1;
    localparam logic [OP_W-1:0] ALU_NOT = 3'h2;
    localparam logic [OP_W-1:0] ALU_SUB = 3'h3;
    localparam logic [OP_W-1:0] ALU_XOR = 3'h4;

    // ---------------------------------------------------------------
    // memory access sizes and the decoded operation
    // ---------------------------------------------------------------
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    typedef struct packed {
        logic       store;
        logic [1:0] size;
        logic       sgn;
    } tfu_memop_t;

    typedef enum logic [1:0] {
        TFU_IDLE  = 2'h0,
        TFU_WAIT  = 2'h1,
        TFU_STALL = 2'h3
    } tfu_ls_state_t;

    // alphabetical codes of both operation sets; each row: store, size, signed
    function automatic tfu_memop_t tfu_decode(input logic [OP_W-1:0] op, input logic big);
        tfu_memop_t d;
        d = '{store: 1'b0, size: SZ_WORD, sgn: 1'b0};
        if (big) begin
            unique case (op)
                3'h0: d = '{1'b0, SZ_HALF, 1'b1};
                3'h1: d = '{1'b0, SZ_HALF, 1'b0};
                3'h2: d = '{1'b0, SZ_BYTE, 1'b1};
                3'h3: d = '{1'b0, SZ_BYTE, 1'b0};
                3'h4: d = '{1'b0, SZ_WORD, 1'b0};
                3'h5: d = '{1'b1, SZ_HALF, 1'b0};
                3'h6: d = '{1'b1, SZ_BYTE, 1'b0};
                3'h7: d = '{1'b1, SZ_WORD, 1'b0};
            endcase
        end else begin
            unique case (op)
                3'h0: d = '{1'b0, SZ_HALF, 1'b1};
                3'h1: d = '{1'b0, SZ_WORD, 1'b0};
                3'h2: d = '{1'b0, SZ_BYTE, 1'b1};
                3'h3: d = '{1'b0, SZ_HALF, 1'b0};
                3'h4: d = '{1'b0, SZ_BYTE, 1'b0};
                3'h5: d = '{1'b1, SZ_HALF, 1'b0};
                3'h6: d = '{1'b1, SZ_WORD, 1'b0};
                3'h7: d = '{1'b1, SZ_BYTE, 1'b0};
            endcase
        end
        return d;
    endfunction : tfu_decode

endpackage : tfu_pkg

// ===== hdl/tfu_shell.sv
// function unit shell: arithmetic unit plus load-store unit on one stall
`timescale 1ns/1ps
// Function
// - operation codes are numbered in alphabetical order of the operation names.
// - operand and result ports are vectors whose widths come from parameters.
// - every operand port, the trigger included, has its own one-bit load strobe.
// - the operation select travels with the trigger and is taken when the trigger loads.
// - an active-low reset clears operand, operation and result state.
// - while the global stall is high the unit freezes and resumes only after it drops; load data the memory returns is still parked or written to the result.
// - a late result past the static latency raises the stall request output.
// - the load-store trigger port width equals the data address width parameter.
// - the load-store unit offers signed and unsigned byte and half loads, word loads and all stores.
// - a strobe captures its operand, and a trigger strobe also starts the operation.
module tfu_shell
    import tfu_pkg::*;
#(
    parameter int unsigned DATA_W     = 32,
    parameter int unsigned ADDR_W     = 32,
    parameter bit          BIG_ENDIAN = 1'b0
) (
    input  wire logic              sys_clk_in,
    input  wire logic              resetn_in,
    input  wire logic              global_stall_in,
    output logic                   stall_req_out,
    input  wire logic [DATA_W-1:0] alu_trigger_operand_in,
    input  wire logic              alu_trigger_strobe_in,
    input  wire logic [DATA_W-1:0] alu_second_operand_in,
    input  wire logic              alu_operand_strobe_in,
    input  wire logic [OP_W-1:0]   alu_op_select_in,
    output logic      [DATA_W-1:0] alu_result_out,
    input  wire logic [ADDR_W-1:0] ldst_trigger_operand_in,
    input  wire logic              ldst_trigger_strobe_in,
    input  wire logic [LS_DW-1:0]  ldst_second_operand_in,
    input  wire logic              ldst_operand_strobe_in,
    input  wire logic [OP_W-1:0]   ldst_op_select_in,
    output logic      [LS_DW-1:0]  ldst_result_out,
    output logic                   mem_req_out,
    output logic                   mem_we_out,
    output logic      [ADDR_W-3:0] mem_addr_out,
    output logic      [BE_W-1:0]   mem_be_out,
    output logic      [LS_DW-1:0]  mem_wdata_out,
    input  wire logic [LS_DW-1:0]  mem_rdata_in,
    input  wire logic              mem_rvalid_in
);

    // ---------------------------------------------------------------
    // arithmetic unit
    // ---------------------------------------------------------------
    tfu_alu #(
        .DATA_W (DATA_W)
    ) i_tfu_alu (
        .sys_clk_in         (sys_clk_in),
        .resetn_in          (resetn_in),
        .global_stall_in    (global_stall_in),
        .trigger_operand_in (alu_trigger_operand_in),
        .trigger_strobe_in  (alu_trigger_strobe_in),
        .second_operand_in  (alu_second_operand_in),
        .operand_strobe_in  (alu_operand_strobe_in),
        .op_select_in       (alu_op_select_in),
        .result_out         (alu_result_out)
    );

    // ---------------------------------------------------------------
    // load-store operand capture
    // ---------------------------------------------------------------
    tfu_ls_state_t     state_reg;
    tfu_memop_t        dec;
    tfu_memop_t        op_reg;
    logic [LS_DW-1:0]  wdata_reg;
    logic [LS_DW-1:0]  store_val;
    logic [LANE_W-1:0] lane_reg;
    logic [LANE_W-1:0] lane;
    logic [CNT_W-1:0]  cnt_reg;
    logic [LS_DW-1:0]  buf_reg;
    logic              got_reg;
    logic              fire;
    logic [LS_DW-1:0]  load_src;
    logic [LS_DW-1:0]  load_val;
    logic              finish_wait;

    assign fire      = ldst_trigger_strobe_in && !global_stall_in;
    assign dec       = tfu_decode(ldst_op_select_in, BIG_ENDIAN);
    assign store_val = ldst_operand_strobe_in ? ldst_second_operand_in : wdata_reg;
    // byte lane of the addressed byte inside the word differs with byte order
    assign lane      = BIG_ENDIAN ? ~ldst_trigger_operand_in[LANE_W-1:0]
                                  : ldst_trigger_operand_in[LANE_W-1:0];

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            wdata_reg <= RST_DATA;
        end else if (ldst_operand_strobe_in && !global_stall_in) begin
            wdata_reg <= ldst_second_operand_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            op_reg   <= '{1'b0, SZ_WORD, 1'b0};
            lane_reg <= '0;
        end else if (fire && !dec.store) begin
            // a store in mid-load must not change how the pending word is cut
            op_reg   <= dec;
            lane_reg <= lane;
        end
    end

    // ---------------------------------------------------------------
    // memory request, registered one cycle after the trigger
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            mem_req_out   <= 1'b0;
            mem_we_out    <= 1'b0;
            mem_addr_out  <= '0;
            mem_be_out    <= '0;
            mem_wdata_out <= RST_DATA;
        end else begin
            mem_req_out <= fire;
            if (fire) begin
                mem_we_out   <= dec.store;
                mem_addr_out <= ldst_trigger_operand_in[ADDR_W-1:LANE_W];
                unique case (dec.size)
                    SZ_BYTE: begin
                        mem_be_out    <= BE_W'(1) << lane;
                        mem_wdata_out <= {4{store_val[7:0]}};
                    end
                    SZ_HALF: begin
                        mem_be_out    <= lane[1] ? 4'hc : 4'h3;
                        mem_wdata_out <= {2{store_val[15:0]}};
                    end
                    default: begin
                        mem_be_out    <= 4'hf;
                        mem_wdata_out <= store_val;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // load data extraction
    // ---------------------------------------------------------------
    assign load_src = mem_rvalid_in ? mem_rdata_in : buf_reg;

    always_comb begin
        logic [7:0]  b8;
        logic [15:0] h16;
        b8       = load_src[8*lane_reg +: 8];
        h16      = lane_reg[1] ? load_src[31:16] : load_src[15:0];
        load_val = load_src;
        unique case (op_reg.size)
            SZ_BYTE: load_val = {{24{op_reg.sgn & b8[7]}}, b8};
            SZ_HALF: load_val = {{16{op_reg.sgn & h16[15]}}, h16};
            default: load_val = load_src;
        endcase
    end

    // ---------------------------------------------------------------
    // latency tracking and late-data stall request
    // ---------------------------------------------------------------
    assign finish_wait = state_reg == TFU_WAIT && !global_stall_in && cnt_reg == LS_LAST;

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state_reg <= TFU_IDLE;
            cnt_reg   <= CNT_ZERO;
        end else if (fire && !dec.store) begin
            state_reg <= TFU_WAIT;
            cnt_reg   <= CNT_ONE;
        end else begin
            unique case (state_reg)
                TFU_IDLE: state_reg <= TFU_IDLE;
                TFU_WAIT: begin
                    if (finish_wait) begin
                        // static latency spent: stall unless the word is in
                        state_reg <= (got_reg || mem_rvalid_in) ? TFU_IDLE : TFU_STALL;
                    end else if (!global_stall_in) begin
                        cnt_reg <= cnt_reg + CNT_ONE;
                    end
                end
                TFU_STALL: if (mem_rvalid_in) state_reg <= TFU_IDLE;
                default: state_reg <= TFU_IDLE;
            endcase
        end
    end

    // early data is parked; memory does not obey the stall so it is taken even under the stall
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            got_reg <= 1'b0;
            buf_reg <= RST_DATA;
        end else if (fire && !dec.store) begin
            // a new load drops any word the old one had parked; data still in flight is taken as the new load's
            got_reg <= 1'b0;
        end else if (mem_rvalid_in && state_reg == TFU_WAIT) begin
            got_reg <= 1'b1;
            buf_reg <= mem_rdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            ldst_result_out <= RST_DATA;
        end else if ((finish_wait && (got_reg || mem_rvalid_in))
                     || (state_reg == TFU_STALL && mem_rvalid_in)) begin
            ldst_result_out <= load_val;
        end
    end

    assign stall_req_out = state_reg == TFU_STALL;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    a_stall_blocks_req: assert property (global_stall_in |=> !mem_req_out)
        else $error("memory request issued under stall");
    a_store_issue: assert property (fire && dec.store |=> mem_req_out && mem_we_out)
        else $error("store not issued after trigger");
    a_load_issue: assert property (fire && !dec.store |=> mem_req_out && !mem_we_out)
        else $error("load not issued after trigger");
    a_late_stall_req: assert property (finish_wait && !got_reg && !mem_rvalid_in && !fire |=> stall_req_out)
        else $error("late load did not request stall");
    a_stall_req_release: assert property (stall_req_out && mem_rvalid_in && !fire |=>
        !stall_req_out && ldst_result_out == $past(load_val)) else $error("stall not released on data");
    a_wait_freeze: assert property (state_reg == TFU_WAIT && global_stall_in && !fire |=>
        $stable(cnt_reg) && state_reg == TFU_WAIT) else $error("latency count moved under stall");
    a_word_addr_map: assert property (fire |=>
        mem_addr_out == $past(ldst_trigger_operand_in[ADDR_W-1:LANE_W])) else $error("address mapping wrong");
    a_load_on_time: assert property (fire && !dec.store ##1 (!global_stall_in && !fire)
        ##1 (!global_stall_in && !fire && mem_rvalid_in) |=> state_reg == TFU_IDLE)
        else $error("load latency not kept");

endmodule : tfu_shell
